// >>> src/vin_result_status.sv
// Result formatting, scaling and status area of the voltage input block
//
// Overview of operation
// - Unipolar 15-bit channels report unsigned counts 0 to 32767.
// - Unipolar 16-bit option reports unsigned counts 0 to 65535.
// - Bipolar ranges are always 16-bit two's complement, -32768 to 32767.
// - Count weight is 305, 152 or 76 microvolts by range and resolution.
// - A 24-bit status area starts on an 8-bit boundary.
// - Status byte one: bit0 self-test, bit1 supply missing, bit2 invalid data.
// - Byte two holds channel 1-8 range flags, byte three channels 9-16.
// - Self-test flag is set while the internal self-test has failed.
// - Missing-supply flag is set while external field power is absent.
// - Invalid-data flag is set until the latest configuration is committed.
// - Only the configured number of channels is converted, all by default.
// - Each channel selects its own range and encodes results to match.
// - With scaling enabled each raw count becomes a scaled value word.
// - Scaling maps raw min/max linearly to engineering min/max, clamp optional.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
module vin_result_status
  import vin_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter front end
  output logic conv_start_o,
  output logic [3:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_code_i,
  input wire logic conv_over_i,
  // Fault pins
  input wire logic self_test_fail_i,
  input wire logic supply_missing_i,
  // Interrupt
  output logic irq_o
);

  typedef enum logic [2:0] {S_IDLE, S_START, S_WAIT, S_SCALE, S_STORE} scan_state_type;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  scan_state_type state_r;
  logic [4:0] cfg_r [NUM_CH];
  logic [15:0] raw_word_r [NUM_CH];
  logic [15:0] scaled_r [NUM_CH];
  logic [31:0] sraw_r [NUM_CH];
  logic [31:0] seng_r [NUM_CH];
  logic [15:0] range_flags_r;
  logic [4:0] chen_r;
  logic configured_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_stat_nxt;
  logic [2:0] irq_mask_r;
  logic irq_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [3:0] chan_r;
  logic start_r;
  logic [15:0] fmt_r;
  logic over_r;
  logic scale_go_r;
  logic [1:0] fault_prev_r;
  logic [1:0] fault_lvl;
  logic sc_done;
  logic [15:0] sc_result;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Place a converter code in the channel's raw word format
  function automatic logic [15:0] fmt_raw(input logic [1:0] rng, input logic u16,
                                          input logic [15:0] code);
    logic [15:0] v;
    v = {1'b0, code[15:1]};
    if (rng[1])
      v = {~code[15], code[14:0]};
    else if (u16)
      v = code;
    return v;
  endfunction

  // Byte-lane merge for a partial write
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        m[b*8 +: 8] = new_v[b*8 +: 8];
    return m;
  endfunction

  // Mask of channels that take part in the scan
  function automatic logic [15:0] chan_mask(input logic [4:0] n);
    logic [15:0] m;
    m = 16'h0;
    for (int c = 0; c < NUM_CH; c++)
      if (5'(c) < n)
        m[c] = 1'b1;
    return m;
  endfunction

  // ---------------------------------------------------------------
  // Fault pin synchronisers
  // ---------------------------------------------------------------
  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({supply_missing_i, self_test_fail_i}),
    .level_o(fault_lvl)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = req & wb_we_i;
  wire [2:0] region = wb_adr_i[8:6];
  wire [3:0] idx = wb_adr_i[5:2];
  wire low_page = (region == 3'h0);
  wire hit_status = low_page & (wb_adr_i[5:0] == ADDR_STATUS[5:0]);
  wire hit_ctrl = low_page & (wb_adr_i[5:0] == ADDR_CTRL[5:0]);
  wire hit_istat = low_page & (wb_adr_i[5:0] == ADDR_IRQ_STAT[5:0]);
  wire hit_imask = low_page & (wb_adr_i[5:0] == ADDR_IRQ_MASK[5:0]);
  wire hit_cfg = (region == REGION_CFG);
  wire hit_raw = (region == REGION_RAW);
  wire hit_scaled = (region == REGION_SCALED);
  wire hit_sraw = (region == REGION_SRAW);
  wire hit_seng = (region == REGION_SENG);
  wire [31:0] ctrl_wr = merge({23'h0, configured_r, 3'h0, chen_r}, wb_dat_i, wb_sel_i);
  wire [31:0] cfg_wr = merge({27'h0, cfg_r[idx]}, wb_dat_i, wb_sel_i);
  wire cfg_change = wr & (hit_ctrl | hit_cfg | hit_sraw | hit_seng);
  wire commit = wr & hit_ctrl & ctrl_wr[CTRL_COMMIT_BIT];

  // Channel count of zero or above the part size means all channels
  wire [4:0] chen_eff = ((chen_r == 5'h0) || (chen_r > 5'(NUM_CH))) ? 5'(NUM_CH) : chen_r;
  wire [15:0] active_mask = chan_mask(chen_eff);

  // ---------------------------------------------------------------
  // Status area
  // ---------------------------------------------------------------

  // Unused upper bits of byte one are zero; idle channels report in range
  wire [7:0] fault_byte = {5'h0, ~configured_r, fault_lvl[1], fault_lvl[0]};
  wire [15:0] range_bytes = range_flags_r & active_mask;
  wire [31:0] status_word = {8'h0, range_bytes[15:8], range_bytes[7:0], fault_byte};

  // Read multiplexer; unmapped addresses read as zero
  wire [31:0] rd_data =
    hit_status ? status_word :
    hit_ctrl ? {23'h0, configured_r, 3'h0, chen_r} :
    hit_istat ? {29'h0, irq_stat_r} :
    hit_imask ? {29'h0, irq_mask_r} :
    hit_cfg ? {count_weight(cfg_r[idx][1:0], cfg_r[idx][CFG_U16_BIT]),
               11'h0, cfg_r[idx]} :
    hit_raw ? {16'h0, raw_word_r[idx]} :
    hit_scaled ? {16'h0, scaled_r[idx]} :
    hit_sraw ? sraw_r[idx] :
    hit_seng ? seng_r[idx] : 32'h0;

  // ---------------------------------------------------------------
  // Bus slave: ack one cycle after the request, dropped the next
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= req;
      if (req)
        dat_r <= rd_data;
    end
  end

  // Global configuration; any later change except to the interrupt mask invalidates until recommitted
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chen_r <= CHEN_RESET;
      configured_r <= 1'b0;
      irq_mask_r <= 3'h0;
    end
    else
    begin
      if (wr & hit_ctrl)
        chen_r <= ctrl_wr[4:0];
      if (commit)
        configured_r <= 1'b1;
      else if (cfg_change)
        configured_r <= 1'b0;
      if (wr & hit_imask & wb_sel_i[0])
        irq_mask_r <= wb_dat_i[2:0];
    end
  end

  // Per-channel configuration and scaling limits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        cfg_r[c] <= CFG_RESET;
        sraw_r[c] <= {RAW_MAX_RESET, RAW_MIN_RESET};
        seng_r[c] <= {ENG_MAX_RESET, ENG_MIN_RESET};
      end
    end
    else
    begin
      if (wr & hit_cfg)
        cfg_r[idx] <= cfg_wr[4:0];
      if (wr & hit_sraw)
        sraw_r[idx] <= merge(sraw_r[idx], wb_dat_i, wb_sel_i);
      if (wr & hit_seng)
        seng_r[idx] <= merge(seng_r[idx], wb_dat_i, wb_sel_i);
    end
  end

  // ---------------------------------------------------------------
  // Conversion scan
  // ---------------------------------------------------------------
  wire [4:0] cur_cfg = cfg_r[chan_r];
  wire last_chan = (5'(chan_r) + 5'h1 >= chen_eff);

  lin_scaler u_scaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(scale_go_r),
    .raw_signed_i(cur_cfg[1]),
    .clamp_i(cur_cfg[CFG_CLAMP_BIT]),
    .raw_i(fmt_r),
    .raw_min_i(sraw_r[chan_r][15:0]),
    .raw_max_i(sraw_r[chan_r][31:16]),
    .eng_min_i(seng_r[chan_r][15:0]),
    .eng_max_i(seng_r[chan_r][31:16]),
    .done_o(sc_done),
    .result_o(sc_result)
  );

  // Scan walks channels 0 up to the enabled count, then starts again;
  // fewer channels shorten the pass since disabled ones are never requested
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= S_IDLE;
      chan_r <= 4'h0;
      start_r <= 1'b0;
      fmt_r <= 16'h0;
      over_r <= 1'b0;
      scale_go_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      scale_go_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          chan_r <= 4'h0;
          state_r <= S_START;
        end
        S_START:
        begin
          start_r <= 1'b1;
          state_r <= S_WAIT;
        end
        S_WAIT:
        begin
          if (conv_done_i)
          begin
            fmt_r <= fmt_raw(cur_cfg[1:0], cur_cfg[CFG_U16_BIT], conv_code_i);
            over_r <= conv_over_i;
            scale_go_r <= cur_cfg[CFG_SCALE_BIT];
            state_r <= cur_cfg[CFG_SCALE_BIT] ? S_SCALE : S_STORE;
          end
        end
        S_SCALE:
        begin
          if (sc_done)
            state_r <= S_STORE;
        end
        S_STORE:
        begin
          chan_r <= last_chan ? 4'h0 : chan_r + 4'h1;
          state_r <= S_START;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // Result words and range flags are written once per conversion
  wire store = (state_r == S_STORE);
  wire range_rise = store & over_r & ~range_flags_r[chan_r];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      range_flags_r <= 16'h0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        raw_word_r[c] <= 16'h0;
        scaled_r[c] <= 16'h0;
      end
    end
    else
    begin
      if (store)
      begin
        raw_word_r[chan_r] <= fmt_r;
        range_flags_r[chan_r] <= over_r;
      end
      if (sc_done)
        scaled_r[chan_r] <= sc_result;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------

  // A fault edge, a range entry and a finished pass are the events;
  // a new event in the clearing cycle survives the clear
  wire fault_rise = |(fault_lvl & ~fault_prev_r);
  wire [2:0] irq_set = {fault_rise, range_rise, store & last_chan};
  wire [2:0] irq_clr = (wr & hit_istat & wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_r <= 3'h0;
      fault_prev_r <= 2'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      fault_prev_r <= fault_lvl;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign conv_start_o = start_r;
  assign conv_chan_o = chan_r;
  assign irq_o = irq_r;

endmodule

// >>> src/vin_pkg.sv
// Constants, register map and field layout of the voltage input result block
package vin_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam logic [4:0] CHEN_RESET = 5'h10;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [8:0] ADDR_STATUS = 9'h000;
  localparam logic [8:0] ADDR_CTRL = 9'h004;
  localparam logic [8:0] ADDR_IRQ_STAT = 9'h008;
  localparam logic [8:0] ADDR_IRQ_MASK = 9'h00c;
  localparam logic [2:0] REGION_CFG = 3'h1;
  localparam logic [2:0] REGION_RAW = 3'h2;
  localparam logic [2:0] REGION_SCALED = 3'h3;
  localparam logic [2:0] REGION_SRAW = 3'h4;
  localparam logic [2:0] REGION_SENG = 3'h5;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_RANGE_LSB = 0;
  localparam int CFG_U16_BIT = 2;
  localparam int CFG_SCALE_BIT = 3;
  localparam int CFG_CLAMP_BIT = 4;
  localparam int CFG_WEIGHT_LSB = 16;
  localparam int CTRL_COMMIT_BIT = 8;
  localparam int ST_SELFTEST_BIT = 0;
  localparam int ST_SUPPLY_BIT = 1;
  localparam int ST_INVALID_BIT = 2;
  localparam int IRQ_SCAN_BIT = 0;
  localparam int IRQ_RANGE_BIT = 1;
  localparam int IRQ_FAULT_BIT = 2;

  // ---------------------------------------------------------------
  // Range codes and count weights in microvolts
  // ---------------------------------------------------------------
  localparam logic [1:0] RANGE_UNI10 = 2'h0;
  localparam logic [1:0] RANGE_UNI5 = 2'h1;
  localparam logic [1:0] RANGE_BI10 = 2'h2;
  localparam logic [1:0] RANGE_BI5 = 2'h3;
  localparam logic [15:0] WEIGHT_305_UV = 16'h0131;
  localparam logic [15:0] WEIGHT_152_UV = 16'h0098;
  localparam logic [15:0] WEIGHT_76_UV = 16'h004c;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [15:0] RAW_MIN_RESET = 16'h0000;
  localparam logic [15:0] RAW_MAX_RESET = 16'h7fff;
  localparam logic [15:0] ENG_MIN_RESET = 16'h0000;
  localparam logic [15:0] ENG_MAX_RESET = 16'h0064;
  localparam int DIV_STEPS = 36;

  // Weight of one raw count for a range and resolution choice
  function automatic logic [15:0] count_weight(input logic [1:0] rng, input logic u16);
    logic [15:0] w;
    w = WEIGHT_305_UV;
    if (rng == RANGE_UNI10)
      w = u16 ? WEIGHT_152_UV : WEIGHT_305_UV;
    else if (rng == RANGE_UNI5)
      w = u16 ? WEIGHT_76_UV : WEIGHT_152_UV;
    else if (rng == RANGE_BI5)
      w = WEIGHT_152_UV;
    return w;
  endfunction

endpackage

// >>> src/pin_sync.sv
// Two-stage synchroniser for the fault pins
`timescale 1ns/1ns
module pin_sync
  import vin_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and synchronised levels
  input wire logic [1:0] pin_i,
  output logic [1:0] level_o
);

  logic [1:0] meta_r;
  logic [1:0] level_r;

  // First stage is read only by the second one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 2'h0;
      level_r <= 2'h0;
    end
    else
    begin
      meta_r <= pin_i;
      level_r <= meta_r;
    end
  end

  assign level_o = level_r;

endmodule

// >>> src/lin_scaler.sv
// Linear raw-to-engineering scaler with optional clamping
`timescale 1ns/1ns
module lin_scaler
  import vin_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic start_i,
  input wire logic raw_signed_i,
  input wire logic clamp_i,
  input wire logic [15:0] raw_i,
  input wire logic [15:0] raw_min_i,
  input wire logic [15:0] raw_max_i,
  input wire logic [15:0] eng_min_i,
  input wire logic [15:0] eng_max_i,
  // Answer
  output logic done_o,
  output logic [15:0] result_o
);

  typedef enum logic [1:0] {SC_IDLE, SC_DIV, SC_DONE} sc_state_type;

  sc_state_type state_r;
  logic [35:0] rem_r;
  logic [35:0] quot_r;
  logic [17:0] den_r;
  logic neg_r;
  logic [5:0] cnt_r;
  logic clamp_r;
  logic signed [15:0] emin_r;
  logic signed [15:0] emax_r;
  logic done_r;
  logic [15:0] result_r;

  // Raw words widen as signed or unsigned after the channel's format
  function automatic logic signed [17:0] widen(input logic [15:0] v, input logic s);
    return s ? {{2{v[15]}}, v} : {2'b00, v};
  endfunction

  logic signed [17:0] dx;
  logic signed [17:0] dr;
  logic signed [17:0] de;
  logic signed [35:0] num;
  logic [35:0] num_mag;
  logic [17:0] den_mag;
  logic [35:0] rem_sh;
  logic [36:0] trial;
  logic signed [36:0] q_s;
  logic signed [37:0] sum;
  logic signed [15:0] lo;
  logic signed [15:0] hi;
  logic signed [37:0] lim_lo;
  logic signed [37:0] lim_hi;
  logic [15:0] final_v;

  // Numerator and denominator of the linear map
  assign dx = widen(raw_i, raw_signed_i) - widen(raw_min_i, raw_signed_i);
  assign dr = widen(raw_max_i, raw_signed_i) - widen(raw_min_i, raw_signed_i);
  assign de = 18'(signed'(eng_max_i)) - 18'(signed'(eng_min_i));
  assign num = dx * de;
  assign num_mag = num[35] ? 36'(-num) : 36'(num);
  assign den_mag = dr[17] ? 18'(-dr) : 18'(dr);

  // One restoring division step per clock
  assign rem_sh = {rem_r[34:0], quot_r[35]};
  assign trial = {1'b0, rem_sh} - {19'h0, den_r};

  // Result, clamped to the engineering limits when clamping is set, else to 16 bits
  assign q_s = neg_r ? -37'(signed'({1'b0, quot_r})) : 37'(signed'({1'b0, quot_r}));
  assign sum = 38'(emin_r) + 38'(q_s);
  assign lo = (emin_r < emax_r) ? emin_r : emax_r;
  assign hi = (emin_r < emax_r) ? emax_r : emin_r;
  assign lim_lo = clamp_r ? 38'(lo) : -38'sd32768;
  assign lim_hi = clamp_r ? 38'(hi) : 38'sd32767;
  assign final_v = (sum < lim_lo) ? lim_lo[15:0] :
                   (sum > lim_hi) ? lim_hi[15:0] : sum[15:0];

  // Divider sequence; a zero raw span yields the engineering minimum
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= SC_IDLE;
      rem_r <= 36'h0;
      quot_r <= 36'h0;
      den_r <= 18'h0;
      neg_r <= 1'b0;
      cnt_r <= 6'h0;
      clamp_r <= 1'b0;
      emin_r <= 16'sh0;
      emax_r <= 16'sh0;
      done_r <= 1'b0;
      result_r <= 16'h0;
    end
    else
    begin
      done_r <= 1'b0;
      case (state_r)
        SC_IDLE:
        begin
          if (start_i)
          begin
            rem_r <= 36'h0;
            quot_r <= (den_mag == 18'h0) ? 36'h0 : num_mag;
            den_r <= (den_mag == 18'h0) ? 18'h1 : den_mag;
            neg_r <= num[35] ^ dr[17];
            cnt_r <= 6'(DIV_STEPS);
            clamp_r <= clamp_i;
            emin_r <= signed'(eng_min_i);
            emax_r <= signed'(eng_max_i);
            state_r <= SC_DIV;
          end
        end
        SC_DIV:
        begin
          if (trial[36])
          begin
            rem_r <= rem_sh;
            quot_r <= {quot_r[34:0], 1'b0};
          end
          else
          begin
            rem_r <= trial[35:0];
            quot_r <= {quot_r[34:0], 1'b1};
          end
          cnt_r <= cnt_r - 6'h1;
          if (cnt_r == 6'h1)
            state_r <= SC_DONE;
        end
        SC_DONE:
        begin
          result_r <= final_v;
          done_r <= 1'b1;
          state_r <= SC_IDLE;
        end
        default:
          state_r <= SC_IDLE;
      endcase
    end
  end

  assign done_o = done_r;
  assign result_o = result_r;

endmodule

// >>> tb/vin_result_status_monitor.sv
// Port-level assertions of the voltage input result block
`timescale 1ns/1ns
module vin_result_status_monitor
  import vin_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Converter, pins and interrupt
  input wire logic conv_start_o,
  input wire logic [3:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_code_i,
  input wire logic conv_over_i,
  input wire logic self_test_fail_i,
  input wire logic supply_missing_i,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [3:0] prev_chan_r;
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire [1:0] rng = wb_dat_o[1:0];
  wire [15:0] w_uni10 = wb_dat_o[2] ? WEIGHT_152_UV : WEIGHT_305_UV;
  wire [15:0] w_uni5 = wb_dat_o[2] ? WEIGHT_76_UV : WEIGHT_152_UV;
  wire [15:0] w_bi = (rng == RANGE_BI10) ? WEIGHT_305_UV : WEIGHT_152_UV;
  wire [15:0] exp_weight = (rng == RANGE_UNI10) ? w_uni10 : (rng == RANGE_UNI5) ? w_uni5 : w_bi;
  // Last channel started; reset to 15 so the first start may be channel 0
  always_ff @(posedge clk_i)
    if (rst_i)
      prev_chan_r <= 4'hf;
    else if (conv_start_o)
      prev_chan_r <= conv_chan_o;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  chan_hold_a: assert property (conv_start_o |=> $stable(conv_chan_o))
    else $error("channel moved right after start");
  chan_order_a: assert property (conv_start_o |->
    conv_chan_o == prev_chan_r + 4'h1 || conv_chan_o == 4'h0)
    else $error("channel scan out of order");
  rescan_soon_a: assert property (conv_done_i |-> ##[2:60] conv_start_o)
    else $error("scan stalled after a result");
  status_zero_a: assert property (rd_ack && wb_adr_i[8:2] == 7'h00 |->
    wb_dat_o[7:3] == 5'h00 && wb_dat_o[31:24] == 8'h00)
    else $error("unused status bits not zero");
  weight_code_a: assert property (rd_ack && wb_adr_i[8:6] == REGION_CFG |->
    wb_dat_o[31:16] == exp_weight)
    else $error("count weight wrong for range");
endmodule

bind vin_result_status vin_result_status_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i),
  .conv_code_i(conv_code_i), .conv_over_i(conv_over_i), .self_test_fail_i(self_test_fail_i),
  .supply_missing_i(supply_missing_i), .irq_o(irq_o));

// >>> tb/conv_model.sv
// Behavioural converter front end that answers start requests
`timescale 1ns/1ns
module conv_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests
  input wire logic start_i,
  input wire logic [3:0] chan_i,
  // Answer
  output logic done_o = 1'b0,
  output logic [15:0] code_o = 16'h0000,
  output logic over_o = 1'b0
);
  logic [15:0] code_tbl [16];
  logic [15:0] over_tbl;
  logic [3:0] chan_r;
  int wait_r;
  // Odd channels answer slowly; lines invert between answers so stale data never matches
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    code_o <= ~code_o;
    over_o <= ~over_o;
    if (rst_i)
      wait_r <= 0;
    else if (start_i)
    begin
      wait_r <= chan_i[0] ? 14 : 2;
      chan_r <= chan_i;
    end
    else if (wait_r == 1)
    begin
      wait_r <= 0;
      done_o <= 1'b1;
      code_o <= code_tbl[chan_r];
      over_o <= over_tbl[chan_r];
    end
    else if (wait_r > 1)
      wait_r <= wait_r - 1;
  end
endmodule

// >>> tb/vin_result_status_tb.sv
// Self-checking bench of the voltage input result block
`timescale 1ns/1ns
module vin_result_status_tb
  import vin_pkg::*;
;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [8:0] wb_adr_i = 9'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rdat;
  logic [15:0] conv_code_i;
  logic [3:0] conv_chan_o;
  logic wb_ack_o, conv_start_o, conv_done_i, conv_over_i, irq_o;
  logic self_test_fail_i = 1'b0;
  logic supply_missing_i = 1'b0;
  int mismatches = 0;
  int compares = 0;
  localparam logic [15:0] CODES [6] = '{16'hfffe, 16'h1234, 16'h0000, 16'hffff, 16'hfedc, 16'h0001};
  localparam logic [15:0] RAWS [6] = '{16'h7fff, 16'h091a, 16'h8000, 16'h7fff, 16'hfedc, 16'h0001};
  localparam logic [15:0] WTS [6] = '{WEIGHT_305_UV, WEIGHT_152_UV, WEIGHT_305_UV,
    WEIGHT_152_UV, WEIGHT_152_UV, WEIGHT_76_UV};
  vin_result_status u_vin_result_status (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i), .conv_code_i(conv_code_i),
    .conv_over_i(conv_over_i), .self_test_fail_i(self_test_fail_i),
    .supply_missing_i(supply_missing_i), .irq_o(irq_o));
  conv_model u_conv_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o),
    .chan_i(conv_chan_o), .done_o(conv_done_i), .code_o(conv_code_i), .over_o(conv_over_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered just after an edge; the watchdog bounds the wait for ack
  task automatic xfer(input logic we, input logic [8:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [8:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask
  task automatic rd(input logic [8:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    chk(rdat, exp);
  endtask
  // Clear events and wait for the next unmasked one
  task automatic wait_irq();
    wr(ADDR_IRQ_STAT, 32'h7);
    while (irq_o !== 1'b1)
      @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial
    forever #2 clk_i = ~clk_i;
  initial
  begin
    #80000;
    mismatches++;
    conclude();
  end
  initial
  begin
    for (int i = 0; i < 6; i++)
      u_conv_model.code_tbl[i] = CODES[i];
    u_conv_model.over_tbl = 16'h0092;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_STATUS, 32'h0000_0004);
    rd(ADDR_CTRL, 32'h0000_0010);
    for (int i = 0; i < 6; i++)
    begin
      wr(9'h040 + 9'(i * 4), 32'(i));
      rd(9'h040 + 9'(i * 4), {WTS[i], 16'(i)});
    end
    wr(ADDR_CTRL, 32'h0000_0106);
    rd(ADDR_CTRL, 32'h0000_0106);
    wr(ADDR_IRQ_MASK, 32'h1);
    wait_irq();
    wait_irq();
    rd(ADDR_STATUS, 32'h0000_1200);
    for (int i = 0; i < 6; i++)
      rd(9'h080 + 9'(i * 4), {16'h0, RAWS[i]});
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd(9'h1fc, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h4);
    supply_missing_i <= 1'b1;
    wait_irq();
    rd(ADDR_STATUS, 32'h0000_1202);
    wr(ADDR_IRQ_MASK, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    self_test_fail_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(ADDR_STATUS, 32'h0000_1203);
    self_test_fail_i <= 1'b0;
    supply_missing_i <= 1'b0;
    u_conv_model.over_tbl[1] <= 1'b0;
    wr(9'h040, 32'h08);
    wr(9'h044, 32'h09);
    wr(9'h04c, 32'h1b);
    wr(9'h10c, 32'h3fff_0000);
    rd(ADDR_CTRL, 32'h0000_0006);
    wr(ADDR_CTRL, 32'h0000_0106);
    wr(ADDR_IRQ_MASK, 32'h1);
    wait_irq();
    wait_irq();
    rd(9'h0c0, 32'h0000_0064);
    rd(9'h0c4, 32'h0000_0007);
    rd(9'h0cc, 32'h0000_0064);
    rd(ADDR_STATUS, 32'h0000_1000);
    conclude();
  end
endmodule
